// ==== logic/async_mem_pkg.sv ====
// Purpose: Shared constants, types and helpers for the async memory strobe sequencer
// Assumes: One system clock; all phase counts are in whole clock periods
// Notes:   Setup, strobe and hold counts of zero are stretched to one cycle; a zero turnaround is skipped
package async_mem_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int ADDR_W              = 21;
    localparam int BANK_W              = 2;
    localparam int CS_W                = 4;
    localparam int CS_SEL_W            = 2;
    localparam int TURN_W              = 2;
    localparam int SETUP_W             = 4;
    localparam int STROBE_W            = 6;
    localparam int HOLD_W              = 3;
    localparam int WAIT_W              = 8;
    localparam int PHASE_W             = 6;
    localparam int RUN_W               = 12;
    localparam int SYSCLK_MHZ          = 40;
    localparam int SYSCLK_PERIOD_NS    = 1000 / SYSCLK_MHZ;
    localparam int WAIT_UNIT_CYCLES    = 16;
    localparam int WAIT_RELEASE_CYCLES = 4;
    localparam int WAIT_COUNT_RANGE    = 256;

    localparam logic [PHASE_W-1:0] PHASE_ZERO  = 6'h00;
    localparam logic [PHASE_W-1:0] PHASE_ONE   = 6'h01;
    localparam logic [PHASE_W-1:0] RELEASE_LEN = PHASE_W'(WAIT_RELEASE_CYCLES);
    localparam logic [CS_W-1:0]    CS_IDLE     = 4'hf;
    localparam logic [CS_W-1:0]    CS_ONE      = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_TURN, S_SETUP, S_STROBE, S_WAIT, S_RELEASE, S_HOLD} phase_e;

    typedef struct packed {
        logic [TURN_W-1:0]   turnaroundCycles;
        logic [SETUP_W-1:0]  readSetupCycles;
        logic [STROBE_W-1:0] readStrobeCycles;
        logic [HOLD_W-1:0]   readHoldCycles;
        logic [SETUP_W-1:0]  writeSetupCycles;
        logic [STROBE_W-1:0] writeStrobeCycles;
        logic [HOLD_W-1:0]   writeHoldCycles;
        logic [WAIT_W-1:0]   maxWaitLimit;
        logic                extendedWaitEnable;
        logic                selectStrobe;
    } async_cfg_s;

    typedef struct packed {
        logic                write;
        logic [CS_SEL_W-1:0] chip;
        logic [BANK_W-1:0]   bank;
        logic [ADDR_W-1:0]   addr;
    } mem_req_s;

    typedef struct packed {
        logic [CS_W-1:0]   chipSelectN;
        logic              readStrobeN;
        logic              writeStrobeN;
        logic [BANK_W-1:0] bankAddress;
        logic [ADDR_W-1:0] memoryAddress;
    } mem_pins_s;

    typedef struct packed {
        phase_e              phase;
        logic [PHASE_W-1:0]  count;
        logic                isWrite;
        logic                lastWrite;
        logic                extended;
        logic                ready;
        logic                done;
        logic                timeout;
        logic [WAIT_W-1:0]   stretch;
        async_cfg_s          cfg;
        mem_req_s            req;
        mem_pins_s           pins;
    } seq_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_s;

    typedef struct packed {
        logic [WAIT_W-1:0]  units;
        logic [PHASE_W-1:0] sub;
    } stretch_s;

    // ------------------------------------------------------------
    // Phase length helpers
    // ------------------------------------------------------------
    function automatic logic [PHASE_W-1:0] phaseLen(input logic [PHASE_W-1:0] n);
        return (n == PHASE_ZERO) ? PHASE_ONE : n;
    endfunction : phaseLen

    function automatic logic [PHASE_W-1:0] setupOf(input async_cfg_s c, input logic w);
        return phaseLen(w ? PHASE_W'(c.writeSetupCycles) : PHASE_W'(c.readSetupCycles));
    endfunction : setupOf

    function automatic logic [PHASE_W-1:0] strobeOf(input async_cfg_s c, input logic w);
        return phaseLen(w ? PHASE_W'(c.writeStrobeCycles) : PHASE_W'(c.readStrobeCycles));
    endfunction : strobeOf

    function automatic logic [PHASE_W-1:0] holdOf(input async_cfg_s c, input logic w);
        return phaseLen(w ? PHASE_W'(c.writeHoldCycles) : PHASE_W'(c.readHoldCycles));
    endfunction : holdOf

endpackage : async_mem_pkg

// ==== logic/async_memory_strobe_sequencer.sv ====
// Purpose: Orders select, address and strobes for an external async memory access
// Assumes: Requester holds a request until accepted; config is captured per access
// Notes:   Outputs reflect the phase held in the state register
`timescale 1ns/1ps
module async_memory_strobe_sequencer (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Configuration
    input  wire async_mem_pkg::async_cfg_s     cfg,
    // Request side
    input  wire logic                          reqValid,
    input  wire async_mem_pkg::mem_req_s       req,
    output logic                               reqReady,
    output logic                               accessDone,
    output logic                               waitTimeout,
    output logic [async_mem_pkg::WAIT_W-1:0]   waitStretchCount,
    // Memory pins
    output logic [async_mem_pkg::CS_W-1:0]     chipSelectN,
    output logic [async_mem_pkg::CS_W-1:0]     chipSelectAltN,
    output logic                               readStrobeN,
    output logic                               writeStrobeN,
    output logic [async_mem_pkg::BANK_W-1:0]   bankAddress,
    output logic [async_mem_pkg::ADDR_W-1:0]   memoryAddress,
    input  wire logic                          extWaitInput
);
    import async_mem_pkg::*;

    seq_s              st;
    seq_s              nxt;
    logic              waitLevel;
    logic [WAIT_W-1:0] stretchUnits;
    logic              strobeOn;
    logic              active;
    logic              csOn;

    // ------------------------------------------------------------
    // Wait path
    // ------------------------------------------------------------
    wait_sync u_sync (
        .clk          (clk),
        .reset        (reset),
        .extWaitInput (extWaitInput),
        .waitLevel    (waitLevel)
    );

    wait_stretch_counter #(.UNIT(WAIT_UNIT_CYCLES)) u_stretch (
        .clk   (clk),
        .reset (reset),
        .run   (st.phase == S_WAIT),
        .clear (st.phase == S_SETUP),
        .units (stretchUnits)
    );

    function automatic logic [CS_W-1:0] chipDecode(input logic [CS_SEL_W-1:0] sel);
        return ~(CS_ONE << sel);
    endfunction : chipDecode

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt         = st;
        nxt.done    = 1'b0;
        nxt.timeout = 1'b0;
        nxt.stretch = stretchUnits;
        case (st.phase)
            S_IDLE: begin
                if (reqValid) begin
                    nxt.cfg      = cfg;
                    nxt.req      = req;
                    nxt.isWrite  = req.write;
                    nxt.extended = 1'b0;
                    if (req.write != st.lastWrite && cfg.turnaroundCycles != '0) begin
                        nxt.phase = S_TURN;
                        nxt.count = PHASE_W'(cfg.turnaroundCycles) - PHASE_ONE;
                    end else begin
                        nxt.phase = S_SETUP;
                        nxt.count = setupOf(cfg, req.write) - PHASE_ONE;
                    end
                end
            end
            S_TURN: begin
                if (st.count == PHASE_ZERO) begin
                    nxt.phase = S_SETUP;
                    nxt.count = setupOf(st.cfg, st.isWrite) - PHASE_ONE;
                end else begin
                    nxt.count = st.count - PHASE_ONE;
                end
            end
            S_SETUP: begin
                if (st.count == PHASE_ZERO) begin
                    nxt.phase = S_STROBE;
                    nxt.count = strobeOf(st.cfg, st.isWrite) - PHASE_ONE;
                end else begin
                    nxt.count = st.count - PHASE_ONE;
                end
            end
            S_STROBE: begin
                if (st.count != PHASE_ZERO) begin
                    nxt.count = st.count - PHASE_ONE;
                end else if (st.cfg.extendedWaitEnable && waitLevel) begin
                    nxt.phase    = S_WAIT;
                    nxt.extended = 1'b1;
                end else begin
                    nxt.phase = S_HOLD;
                    nxt.count = holdOf(st.cfg, st.isWrite) - PHASE_ONE;
                end
            end
            S_WAIT: begin
                // Release counts from the synchronised level, so the pin sees the sync delay on top
                if (!waitLevel) begin
                    nxt.phase = S_RELEASE;
                    nxt.count = RELEASE_LEN - PHASE_ONE;
                end else if (stretchUnits >= st.cfg.maxWaitLimit) begin
                    nxt.phase   = S_RELEASE;
                    nxt.count   = RELEASE_LEN - PHASE_ONE;
                    nxt.timeout = 1'b1;
                end
            end
            S_RELEASE: begin
                if (st.count == PHASE_ZERO) begin
                    nxt.phase = S_HOLD;
                    nxt.count = holdOf(st.cfg, st.isWrite) - PHASE_ONE;
                end else begin
                    nxt.count = st.count - PHASE_ONE;
                end
            end
            S_HOLD: begin
                if (st.count == PHASE_ZERO) begin
                    nxt.phase     = S_IDLE;
                    nxt.done      = 1'b1;
                    nxt.lastWrite = st.isWrite;
                end else begin
                    nxt.count = st.count - PHASE_ONE;
                end
            end
            default: begin
                nxt.phase = S_IDLE;
            end
        endcase
        // Pins follow the next phase so they leave a flip-flop aligned with it
        active   = (nxt.phase == S_SETUP) || (nxt.phase == S_STROBE) || (nxt.phase == S_WAIT) ||
                   (nxt.phase == S_RELEASE) || (nxt.phase == S_HOLD);
        strobeOn = (nxt.phase == S_STROBE) || (nxt.phase == S_WAIT) || (nxt.phase == S_RELEASE);
        csOn     = active && (!nxt.cfg.selectStrobe || strobeOn);
        nxt.ready              = (nxt.phase == S_IDLE);
        nxt.pins.chipSelectN   = csOn ? chipDecode(nxt.req.chip) : CS_IDLE;
        nxt.pins.readStrobeN   = !(strobeOn && !nxt.isWrite);
        nxt.pins.writeStrobeN  = !(strobeOn && nxt.isWrite);
        nxt.pins.bankAddress   = nxt.req.bank;
        nxt.pins.memoryAddress = nxt.req.addr;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st           <= '0;
            st.phase     <= S_IDLE;
            st.ready     <= 1'b1;
            st.pins.chipSelectN  <= CS_IDLE;
            st.pins.readStrobeN  <= 1'b1;
            st.pins.writeStrobeN <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    assign reqReady         = st.ready;
    assign accessDone       = st.done;
    assign waitTimeout      = st.timeout;
    assign waitStretchCount = st.stretch;
    assign chipSelectN      = st.pins.chipSelectN;
    // Both select groups share one flop so tracking mode needs no second path
    assign chipSelectAltN   = st.pins.chipSelectN;
    assign readStrobeN      = st.pins.readStrobeN;
    assign writeStrobeN     = st.pins.writeStrobeN;
    assign bankAddress      = st.pins.bankAddress;
    assign memoryAddress    = st.pins.memoryAddress;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic             csLow;
    logic             stbLow;
    logic [RUN_W-1:0] csRun;
    logic [RUN_W-1:0] stbRun;
    logic [RUN_W-1:0] gapRun;

    assign csLow  = (st.pins.chipSelectN != CS_IDLE);
    assign stbLow = !st.pins.readStrobeN || !st.pins.writeStrobeN;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            csRun  <= '0;
            stbRun <= '0;
            gapRun <= '0;
        end else begin
            csRun  <= csLow ? csRun + RUN_W'(1) : '0;
            stbRun <= stbLow ? stbRun + RUN_W'(1) : '0;
            gapRun <= (csLow && !stbLow) ? gapRun + RUN_W'(1) : '0;
        end
    end

    sequence relStrobeLow;
        stbLow[*4] ##1 !stbLow;
    endsequence

    chk_cs_leads_strobe : assert property (@(posedge clk) disable iff (reset)
        ($rose(stbLow) && !st.cfg.selectStrobe) |-> (RUN_W'(setupOf(st.cfg, st.isWrite)) == gapRun))
        else $error("select did not lead strobe by setup count");

    chk_cs_trails_strobe : assert property (@(posedge clk) disable iff (reset)
        ($fell(csLow) && !st.cfg.selectStrobe) |-> (RUN_W'(holdOf(st.cfg, st.isWrite)) == gapRun))
        else $error("select did not trail strobe by hold count");

    chk_cs_tracks_strobe : assert property (@(posedge clk) disable iff (reset)
        st.cfg.selectStrobe |-> (csLow == stbLow))
        else $error("select not tracking strobe");

    chk_strobe_width : assert property (@(posedge clk) disable iff (reset)
        ($fell(stbLow) && !st.extended) |-> (stbRun == RUN_W'(strobeOf(st.cfg, st.isWrite))))
        else $error("strobe width differs from strobe count");

    chk_strobe_stretch : assert property (@(posedge clk) disable iff (reset)
        ($fell(stbLow) && st.extended) |-> (stbRun > RUN_W'(strobeOf(st.cfg, st.isWrite)) + RUN_W'(WAIT_RELEASE_CYCLES)))
        else $error("extended strobe not longer than strobe count");

    chk_wait_release : assert property (@(posedge clk) disable iff (reset)
        (st.phase == S_WAIT && !waitLevel) |=> relStrobeLow)
        else $error("strobe did not end four cycles after wait release");

    chk_write_length : assert property (@(posedge clk) disable iff (reset)
        ($fell(csLow) && st.isWrite && !st.extended && !st.cfg.selectStrobe) |->
        (csRun == RUN_W'(setupOf(st.cfg, 1'b1)) + RUN_W'(strobeOf(st.cfg, 1'b1)) + RUN_W'(holdOf(st.cfg, 1'b1))))
        else $error("write length differs from phase sum");

    chk_write_extended : assert property (@(posedge clk) disable iff (reset)
        ($fell(csLow) && st.isWrite && st.extended && !st.cfg.selectStrobe) |->
        (csRun > RUN_W'(setupOf(st.cfg, 1'b1)) + RUN_W'(strobeOf(st.cfg, 1'b1)) + RUN_W'(holdOf(st.cfg, 1'b1))))
        else $error("extended write not longer than phase sum");

    chk_addr_stable : assert property (@(posedge clk) disable iff (reset)
        (csLow && $past(csLow) && !st.cfg.selectStrobe) |-> ($stable(memoryAddress) && $stable(bankAddress)))
        else $error("address moved while select low");

    chk_wait_timeout : assert property (@(posedge clk) disable iff (reset)
        (st.phase == S_WAIT && waitLevel && stretchUnits >= st.cfg.maxWaitLimit) |=> (waitTimeout and relStrobeLow))
        else $error("wait limit did not end strobe");

    // ------------------------------------------------------------
    // Protocol checks
    // ------------------------------------------------------------
    // Strobe-edge address checks run in both select modes, unlike the select checks
    chk_strobe_exclusive : assert property (@(posedge clk) disable iff (reset)
        !(!readStrobeN && !writeStrobeN))
        else $error("both strobes low");

    chk_no_stretch : assert property (@(posedge clk) disable iff (reset)
        !st.cfg.extendedWaitEnable |-> (st.phase != S_WAIT))
        else $error("wait phase with stretch off");

    chk_done_pulse : assert property (@(posedge clk) disable iff (reset)
        accessDone |=> !accessDone)
        else $error("done longer than one cycle");

    chk_take_busy : assert property (@(posedge clk) disable iff (reset)
        (reqValid && reqReady) |=> !reqReady)
        else $error("ready after request taken");

    chk_timeout_source : assert property (@(posedge clk) disable iff (reset)
        waitTimeout |-> (st.phase == S_RELEASE && st.extended))
        else $error("timeout outside release");

    chk_read_hold : assert property (@(posedge clk) disable iff (reset)
        ($fell(csLow) && !st.isWrite && !st.cfg.selectStrobe) |-> (gapRun == RUN_W'(holdOf(st.cfg, 1'b0))))
        else $error("read hold length wrong");

    chk_write_hold : assert property (@(posedge clk) disable iff (reset)
        ($fell(csLow) && st.isWrite && !st.cfg.selectStrobe) |-> (gapRun == RUN_W'(holdOf(st.cfg, 1'b1))))
        else $error("write hold length wrong");

    chk_addr_setup : assert property (@(posedge clk) disable iff (reset)
        $rose(stbLow) |-> ($stable(memoryAddress) && $stable(bankAddress)))
        else $error("address moved with strobe");

    chk_addr_hold : assert property (@(posedge clk) disable iff (reset)
        $fell(stbLow) |-> ($stable(memoryAddress) && $stable(bankAddress)))
        else $error("address moved at strobe end");

    chk_wait_entry : assert property (@(posedge clk) disable iff (reset)
        $rose(st.extended) |-> (st.phase == S_WAIT))
        else $error("stretch flag outside wait");

endmodule : async_memory_strobe_sequencer

// ==== logic/wait_stretch_counter.sv ====
// Purpose: Counts extended wait time in units of sixteen cycles
// Assumes: Cleared before each strobe phase
// Notes:   Saturates at its top value rather than wrapping
`timescale 1ns/1ps
module wait_stretch_counter #(
    parameter int UNIT = async_mem_pkg::WAIT_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Control
    input  wire logic                        run,
    input  wire logic                        clear,
    // Count
    output logic [async_mem_pkg::WAIT_W-1:0] units
);
    import async_mem_pkg::*;

    localparam logic [PHASE_W-1:0] SUB_LAST = PHASE_W'(UNIT - 1);
    localparam logic [WAIT_W-1:0]  UNITS_TOP = WAIT_W'(WAIT_COUNT_RANGE - 1);

    stretch_s st;
    stretch_s nxt;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        nxt = st;
        if (clear) begin
            nxt = '0;
        end else if (run) begin
            if (st.sub == SUB_LAST) begin
                nxt.sub = PHASE_ZERO;
                if (st.units != UNITS_TOP) begin
                    nxt.units = st.units + WAIT_W'(1);
                end
            end else begin
                nxt.sub = st.sub + PHASE_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign units = st.units;

    chk_unit_step : assert property (@(posedge clk) disable iff (reset)
        (run && !clear && st.sub == SUB_LAST && st.units != UNITS_TOP) |=> (st.units == $past(st.units) + WAIT_W'(1)))
        else $error("wait unit did not advance after sixteen cycles");

endmodule : wait_stretch_counter

// ==== logic/wait_sync.sv ====
// Purpose: Three-stage synchroniser for the external wait pin
// Assumes: Wait input is active high
// Notes:   Level changes only once stages two and three agree
`timescale 1ns/1ps
module wait_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin and synchronised level
    input  wire logic extWaitInput,
    output logic      waitLevel
);
    import async_mem_pkg::*;

    sync_s st;
    sync_s nxt;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_comb begin
        nxt       = st;
        nxt.s1    = extWaitInput;
        nxt.s2    = st.s1;
        nxt.s3    = st.s2;
        if (st.s2 == st.s3) begin
            nxt.level = st.s3;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign waitLevel = st.level;

    chk_sync_agree : assert property (@(posedge clk) disable iff (reset)
        $changed(st.level) |-> ($past(st.s2) == $past(st.s3)) && (st.level == $past(st.s3)))
        else $error("wait level changed without stage agreement");

endmodule : wait_sync

// ==== test/async_mem_model.sv ====
// Purpose: Stand-in for an external async memory that drives the wait pin
// Assumes: Wait pin active high, always driven by the device
// Notes:   Wait only starts at a strobe edge; a late start would miss the strobe
`timescale 1ns/1ps
module async_mem_model (
    // Clock
    input  wire logic clk,
    // Memory strobes
    input  wire logic readStrobeN,
    input  wire logic writeStrobeN,
    // Wait pin and commanded span
    output logic      extWaitInput,
    input  wire logic [31:0] waitSpan
);
    int   left    = 0;
    logic prevLow = 1'b0;
    initial extWaitInput = 1'b0;
    always @(posedge clk) begin
        prevLow <= !(readStrobeN && writeStrobeN);
        if (!(readStrobeN && writeStrobeN) && !prevLow && waitSpan > 0) begin
            left         <= waitSpan;
            extWaitInput <= 1'b1;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            left         <= 0;
            extWaitInput <= 1'b0;
        end
    end
endmodule : async_mem_model

// ==== test/test_async_memory_strobe_sequencer.sv ====
// Purpose: Self-checking bench for the async memory strobe sequencer
// Assumes: Inputs change on the falling edge; outputs sampled there
// Notes:   Wait release is checked against a fixed lag since the pin passes a synchroniser
`timescale 1ns/1ps
module test_async_memory_strobe_sequencer;
    import async_mem_pkg::*;
    logic              clk        = 1'b0;
    logic              reset      = 1'b1;
    async_cfg_s        cfg        = '0;
    logic              reqValid   = 1'b0;
    mem_req_s          req        = '0;
    int                waitSpan   = 0;
    int                badCount   = 0;
    int                checksDone = 0;
    logic              prevWrite  = 1'b0;
    // Pin to strobe: three sync stages, level flop, phase step
    localparam int     SYNC_LAG   = 5;
    logic              reqReady, accessDone, waitTimeout, readStrobeN, writeStrobeN, extWaitInput;
    logic [WAIT_W-1:0] waitStretchCount;
    logic [CS_W-1:0]   chipSelectN, chipSelectAltN;
    logic [BANK_W-1:0] bankAddress;
    logic [ADDR_W-1:0] memoryAddress;

    async_memory_strobe_sequencer i_dut (.clk(clk), .reset(reset), .cfg(cfg), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .accessDone(accessDone), .waitTimeout(waitTimeout),
        .waitStretchCount(waitStretchCount), .chipSelectN(chipSelectN), .chipSelectAltN(chipSelectAltN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .bankAddress(bankAddress),
        .memoryAddress(memoryAddress), .extWaitInput(extWaitInput));
    async_mem_model i_mem (.clk(clk), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .extWaitInput(extWaitInput), .waitSpan(waitSpan));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and verdict
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk

    task automatic endSim();
        if (badCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : endSim

    // ------------------------------------------------------------
    // One access, measured against the phase model
    // ------------------------------------------------------------
    task automatic access(input logic w, input int span, output int width, output int rel, output logic sawTo);
        int          k, fallK, riseK, csLow, pinOff, s, st, h, ta;
        logic        strobe, pinOn;
        logic [31:0] r;
        s  = w ? cfg.writeSetupCycles : cfg.readSetupCycles;
        st = w ? cfg.writeStrobeCycles : cfg.readStrobeCycles;
        h  = w ? cfg.writeHoldCycles : cfg.readHoldCycles;
        s  = (s == 0) ? 1 : s;
        st = (st == 0) ? 1 : st;
        h  = (h == 0) ? 1 : h;
        ta = (w != prevWrite) ? cfg.turnaroundCycles : 0;
        prevWrite = w;
        r = $urandom;
        req = r[25:0];
        req.write = w;
        waitSpan = span;
        reqValid = 1'b1;
        chk("ready", reqReady, 1);
        @(negedge clk);
        reqValid = 1'b0;
        k = 1; fallK = 0; riseK = 0; csLow = 0; pinOff = 0; pinOn = 0; sawTo = 0;
        while (accessDone !== 1'b1 && k < 3000) begin
            strobe = w ? writeStrobeN : readStrobeN;
            if (strobe === 1'b0 && fallK == 0) fallK = k;
            if (strobe === 1'b1 && fallK != 0 && riseK == 0) riseK = k;
            if (extWaitInput === 1'b1) pinOn = 1'b1;
            if (pinOn && extWaitInput === 1'b0 && pinOff == 0) pinOff = k;
            if (waitTimeout === 1'b1) sawTo = 1'b1;
            if (chipSelectN !== CS_IDLE) begin
                csLow++;
                chk("chipSelect", chipSelectN, CS_W'(~(CS_ONE << req.chip)));
            end
            chk("chipSelectAlt", chipSelectAltN, chipSelectN);
            chk("otherStrobe", w ? readStrobeN : writeStrobeN, 1);
            chk("busy", reqReady, 0);
            if (k > ta) begin
                chk("bank", bankAddress, req.bank);
                chk("addr", memoryAddress, req.addr);
            end
            k++;
            @(negedge clk);
        end
        width = riseK - fallK;
        rel   = riseK - pinOff;
        chk("setupLen", fallK, ta + s + 1);
        chk("holdLen", k - riseK, h);
        chk("csLow", csLow, cfg.selectStrobe ? width : s + width + h);
        chk("length", k, ta + s + width + h + 1);
        if (span == 0) chk("strobeLen", width, st);
    endtask : access

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int          width, rel;
        logic        to;
        logic [31:0] r;
        void'($urandom(32'h456ea8b1));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        // Random timing, back to back, both directions and modes
        for (int i = 0; i < 40; i++) begin
            r   = $urandom;
            cfg = 38'({r, $urandom});
            cfg.extendedWaitEnable = 1'b0;
            if (i < 2) cfg = '0;
            access(r[0], 0, width, rel, to);
        end
        // Extended wait, both directions and modes
        for (int i = 0; i < 4; i++) begin
            cfg = '0;
            cfg.readSetupCycles = 4'h2; cfg.writeSetupCycles = 4'h2;
            cfg.readStrobeCycles = 6'h08; cfg.writeStrobeCycles = 6'h08;
            cfg.readHoldCycles = 3'h1; cfg.writeHoldCycles = 3'h1;
            cfg.extendedWaitEnable = 1'b1;
            cfg.maxWaitLimit = 8'hff;
            cfg.selectStrobe = i[1];
            access(i[0], 40 + 16 * i, width, rel, to);
            chk("release", rel, WAIT_RELEASE_CYCLES + SYNC_LAG);
            chk("units", waitStretchCount >= (40 + 16 * i) / 16 - 1 &&
                waitStretchCount <= (40 + 16 * i) / 16 + 1, 1);
            chk("noTimeout", to, 0);
        end
        // Limit reached while the pin stays asserted
        cfg.maxWaitLimit = 8'h01;
        access(1'b0, 200, width, rel, to);
        chk("timeout", to, 1);
        chk("cutShort", width < 60, 1);
        waitSpan = 0;
        endSim();
    end

    initial begin
        #(SYSCLK_PERIOD_NS * 80000);
        badCount++;
        endSim();
    end
endmodule : test_async_memory_strobe_sequencer
